// ===== src/irq_edge_pkg.sv
// Package: register map, reset values and carrier types for the port
// interrupt edge and source selection block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package irq_edge_pkg;

  // Printed offsets are not multiples of four: they are word indices
  localparam logic [11:0] edge_polarity_select_idx = 12'hfcd;
  localparam logic [11:0] shared_source_select_idx = 12'hfce;
  // Event status and mask registers of this block
  localparam logic [11:0] irq_status_idx           = 12'hfd0;
  localparam logic [11:0] irq_mask_idx             = 12'hfd1;
  localparam int          addr_w                   = 14;

  localparam logic [7:0]  edge_polarity_rst        = 8'h00;
  localparam logic [7:0]  shared_source_rst        = 8'h00;
  localparam logic [7:0]  irq_status_rst           = 8'h00;
  localparam logic [7:0]  irq_mask_rst             = 8'h00;

  localparam int          lowvolt_pos              = 7;
  localparam int          comparator_pos           = 6;
  localparam int          num_lines                = 8;

  // Raw sources feeding the request lines
  typedef struct packed {
    logic [7:0] port_a_pin;
    logic [7:0] port_d_pin;
    logic       low_voltage_detector;
    logic       comparator0;
  } irq_sources_t;

  // Request pulses toward the interrupt controller
  typedef struct packed {
    logic [7:0] port_a_req;
    logic [7:0] port_d_req;
  } irq_requests_t;

endpackage : irq_edge_pkg

// ===== src/irq_edge_detect.sv
// Per-line synchroniser and edge detector.
// Assumes input is asynchronous to pclk; output is a one-cycle pulse.
module irq_edge_detect
  import irq_edge_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Line
  input  wire logic raw_in,
  input  wire logic rising_sel,
  output logic      req_pulse
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q,  prev_d;
  logic pulse_q, pulse_d;

  always_comb begin
    sync1_d = raw_in;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    if (rising_sel) begin
      pulse_d = sync2_q & ~prev_q;
    end else begin
      pulse_d = ~sync2_q & prev_q;
    end
  end

  // Reset to zero so no spurious edge after release is guaranteed only
  // for pins idling low; a high pin may give one rising pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      pulse_q <= pulse_d;
    end
  end

  assign req_pulse = pulse_q;

endmodule : irq_edge_detect

// ===== src/irq_edge_select.sv
// Top: edge polarity and shared source selection for port interrupts,
// APB register slave, sticky status with mask and one interrupt line.
// Assumes pins and analog sources are asynchronous to pclk.
//
// Overview of operation
// - Clear polarity bit: falling edge requests
// - Set polarity bit: rising edge requests
// - Per-line select picks pin or internal source on port A lines 7 and 6; other lines stay on pin
// - Bit 7 selects pin 7 or low-voltage
// - Bit 6 selects pin 6 or comparator
module irq_edge_select
  import irq_edge_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [addr_w-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Interrupt sources
  input  wire irq_sources_t        sources,
  // Interrupt controller side
  output irq_requests_t            requests,
  output logic                     irq
);

  // Configuration registers, software owned
  logic [7:0]    edge_pol_q, edge_pol_d;
  logic [7:0]    src_sel_q,  src_sel_d;
  logic [7:0]    mask_q,     mask_d;
  // Sticky event status and the level interrupt
  logic [7:0]    status_q,   status_d;
  logic          irq_q,      irq_d;
  // Bus response, loaded at the setup edge
  logic [31:0]   prdata_q,   prdata_d;
  logic          pslverr_q,  pslverr_d;
  // Request pulses toward the interrupt controller
  irq_requests_t req_q,      req_d;
  // Per-line sources and edge detector outputs
  logic [7:0]    alt_src;
  logic [7:0]    pin_pulse;
  logic [7:0]    alt_pulse;
  logic [7:0]    a_pulse;
  logic [7:0]    d_pulse;
  logic [7:0]    new_events;
  // Bus decode
  logic          setup;
  logic          access;
  logic [11:0]   word_idx;
  logic          aligned;
  logic          hit;
  logic          wr_en;
  logic          rd_status;
  logic [7:0]    rd_byte;

  // Alternate sources: only lines 7 and 6 have one, others stay on pin
  always_comb begin
    alt_src                 = sources.port_a_pin;
    alt_src[lowvolt_pos]    = sources.low_voltage_detector;
    alt_src[comparator_pos] = sources.comparator0;
  end

  // Every source gets its own synchroniser and detector; the choice is
  // made on the pulses, so no raw pin is gated before synchronising and
  // a change of select never fakes an edge. Lines without an alternate
  // feed the pin to both detectors: cheap, and keeps the loop uniform.
  genvar g;
  generate
    for (g = 0; g < num_lines; g++) begin : g_line
      irq_edge_detect u_p (
        .pclk       (pclk),
        .presetn    (presetn),
        .raw_in     (sources.port_a_pin[g]),
        .rising_sel (edge_pol_q[g]),
        .req_pulse  (pin_pulse[g])
      );
      irq_edge_detect u_s (
        .pclk       (pclk),
        .presetn    (presetn),
        .raw_in     (alt_src[g]),
        .rising_sel (edge_pol_q[g]),
        .req_pulse  (alt_pulse[g])
      );
      assign a_pulse[g] = src_sel_q[g] ? alt_pulse[g] : pin_pulse[g];
      irq_edge_detect u_d (
        .pclk       (pclk),
        .presetn    (presetn),
        .raw_in     (sources.port_d_pin[g]),
        .rising_sel (edge_pol_q[g]),
        .req_pulse  (d_pulse[g])
      );
    end
  endgenerate

  // Address decode: word index is byte address over four
  assign setup     = psel & ~penable;
  assign access    = psel & penable;
  assign word_idx  = paddr[addr_w-1:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign hit       = aligned &&
                     (word_idx == edge_polarity_select_idx ||
                      word_idx == shared_source_select_idx ||
                      word_idx == irq_status_idx ||
                      word_idx == irq_mask_idx);
  // Writes land only at the access edge, and only with lane 0 on
  assign wr_en     = access & pwrite & hit & pstrb[0];
  assign rd_status = access & ~pwrite & hit &
                     (word_idx == irq_status_idx);

  // Read byte of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    if (hit) begin
      unique case (word_idx)
        edge_polarity_select_idx: rd_byte = edge_pol_q;
        shared_source_select_idx: rd_byte = src_sel_q;
        irq_status_idx:           rd_byte = status_q;
        irq_mask_idx:             rd_byte = mask_q;
        default:                  rd_byte = 8'h00;
      endcase
    end
  end

  // Configuration next values
  always_comb begin
    edge_pol_d = edge_pol_q;
    src_sel_d  = src_sel_q;
    mask_d     = mask_q;
    if (wr_en) begin
      unique case (word_idx)
        edge_polarity_select_idx: edge_pol_d = pwdata[7:0];
        shared_source_select_idx: src_sel_d  = pwdata[7:0];
        irq_mask_idx:             mask_d     = pwdata[7:0];
        default:                  ;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_pol_q <= edge_polarity_rst;
      src_sel_q  <= shared_source_rst;
      mask_q     <= irq_mask_rst;
    end else begin
      edge_pol_q <= edge_pol_d;
      src_sel_q  <= src_sel_d;
      mask_q     <= mask_d;
    end
  end

  // Status: a read clears only the bits it reported, so an event that
  // lands between setup and access waits for the next read
  always_comb begin
    new_events = a_pulse | d_pulse;
    status_d   = status_q;
    if (rd_status) begin
      status_d = status_q & ~prdata_q[7:0];
    end
    // Set wins over read clear so an edge is never lost
    status_d = status_d | new_events;
    irq_d    = |(status_d & mask_d);
  end

  // Status and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= irq_status_rst;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= irq_d;
    end
  end

  // Response loaded at the setup edge, so it stands through the access
  // phase where a zero-wait master takes it
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = ~hit;
      if (!pwrite) begin
        prdata_d[7:0] = rd_byte;
      end
    end
  end

  // Response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Requests registered for clean timing into the controller
  always_comb begin
    req_d.port_a_req = a_pulse;
    req_d.port_d_req = d_pulse;
  end

  // Request registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  // Zero wait states: pready is the one output not taken from a flop
  assign pready   = 1'b1;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign requests = req_q;
  assign irq      = irq_q;

endmodule : irq_edge_select

// ===== verification/irq_edge_monitor.sv
// Checker: request timing against shadowed polarity and select bits.
// Assumes zero-wait APB writes that land at the access edge.
module irq_edge_monitor
  import irq_edge_pkg::*;
(
  // Clock, reset and bus
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [addr_w-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  // Sources and requests
  input wire irq_sources_t      sources,
  input wire irq_requests_t     requests
);
  logic [7:0] pol_q, pol_d, sel_q, sel_d;
  logic       wr;
  // Shadow copy, so edges can be judged without peeking inside
  always_comb begin
    wr    = psel && penable && pwrite && pstrb[0];
    pol_d = (wr && paddr == {edge_polarity_select_idx, 2'b00}) ?
            pwdata[7:0] : pol_q;
    sel_d = (wr && paddr == {shared_source_select_idx, 2'b00}) ?
            pwdata[7:0] : sel_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q <= 8'h00;
      sel_q <= 8'h00;
    end else begin
      pol_q <= pol_d;
      sel_q <= sel_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_fall;
    !pol_q[0] && $fell(sources.port_d_pin[0])
      |-> ##[3:5] requests.port_d_req[0];
  endproperty
  a_fall: assert property (p_fall) else $error("missing falling req");
  property p_rise;
    pol_q[1] && $rose(sources.port_d_pin[1])
      |-> ##[3:5] requests.port_d_req[1];
  endproperty
  a_rise: assert property (p_rise) else $error("missing rising req");
  property p_pin;
    !sel_q[7] && pol_q[7] && $rose(sources.port_a_pin[7])
      |-> ##[3:5] requests.port_a_req[7];
  endproperty
  a_pin: assert property (p_pin) else $error("pin path lost");
  property p_lvd;
    sel_q[7] && pol_q[7] && $rose(sources.low_voltage_detector)
      |-> ##[3:5] requests.port_a_req[7];
  endproperty
  a_lvd: assert property (p_lvd) else $error("lowvolt path lost");
  property p_cmp;
    sel_q[6] && !pol_q[6] && $fell(sources.comparator0)
      |-> ##[3:5] requests.port_a_req[6];
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator path lost");
  property p_one;
    requests.port_d_req[0] |=> !requests.port_d_req[0];
  endproperty
  a_one: assert property (p_one) else $error("req wider than one");
endmodule : irq_edge_monitor

// ===== verification/irq_src_model.sv
// Far side: port pins and analog event sources.
// Assumes the bench gives the next levels; they change after pclk.
module irq_src_model
  import irq_edge_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Levels in, sources out
  input  wire logic [17:0] level,
  output irq_sources_t     sources
);
  // Low in reset, so release shows no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sources <= '0;
    else sources <= level;
  end
endmodule : irq_src_model

// ===== verification/testbench.sv
// Testbench: random config and source edges against a bench model.
// Assumes zero-wait APB; read data taken at the access edge.
module testbench import irq_edge_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [addr_w-1:0] paddr;
  logic [31:0]       pwdata, prdata, seed;
  logic [17:0]       level, old;
  logic [7:0]        rd, pol, sel, msk, seen, exp;
  logic [3:0]        pstrb;
  irq_sources_t      sources;
  irq_requests_t     requests;
  int                fail_count, cmp_count;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] model(input logic [17:0] o, n);
    logic [7:0] oa, na;
    oa = o[17:10];
    na = n[17:10];
    if (sel[7]) begin oa[7] = o[1]; na[7] = n[1]; end
    if (sel[6]) begin oa[6] = o[0]; na[6] = n[0]; end
    return (pol & ((~oa & na) | (~o[9:2] & n[9:2])))
         | (~pol & ((oa & ~na) | (o[9:2] & ~n[9:2])));
  endfunction : model
  task automatic chk(input string n, input logic [7:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Request held until pready is seen high; data and error taken at that
  // edge; one idle edge follows so back-to-back calls never collide
  task automatic apb(input logic w, input logic [11:0] ix,
                     input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard, well past the roughly 1700 cycles needed
  initial begin
    #100us;
    fail_count++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, level, presetn} = '0;
    pstrb = 4'hf;
    seed  = 32'h775a;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, edge_polarity_select_idx, 8'h00);
    chk("pol rst", edge_polarity_rst, rd);
    apb(1'b0, shared_source_select_idx, 8'h00);
    chk("sel rst", shared_source_rst, rd);
    apb(1'b0, 12'h100, 8'h00);
    chk("unmapped", 8'h01, {rd[6:0], err});
    for (int i = 0; i < 40; i++) begin
      {pol, sel, msk} = 24'(rnd());
      apb(1'b1, edge_polarity_select_idx, pol);
      // A write with lane 0 off must leave the register alone
      pstrb <= 4'he;
      apb(1'b1, edge_polarity_select_idx, ~pol);
      pstrb <= 4'hf;
      apb(1'b1, shared_source_select_idx, sel);
      apb(1'b1, irq_mask_idx, msk);
      apb(1'b0, edge_polarity_select_idx, 8'h00);
      chk("pol", pol, rd);
      apb(1'b0, shared_source_select_idx, 8'h00);
      chk("sel", sel, rd);
      // Drop anything raised by the source switch itself
      repeat (8) @(posedge pclk);
      apb(1'b0, irq_status_idx, 8'h00);
      old = level;
      level <= 18'(rnd());
      seen = 8'h00;
      repeat (10) begin
        @(posedge pclk);
        seen |= requests.port_a_req | requests.port_d_req;
      end
      exp = model(old, level);
      chk("req", exp, seen);
      chk("irq", {7'h0, |(exp & msk)}, {7'h0, irq});
      apb(1'b0, irq_status_idx, 8'h00);
      chk("status", exp, rd);
      chk("irq clr", 8'h00, {7'h0, irq});
    end
    // Second reset in mid-run: pins low first, so release shows no edge
    level <= '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, edge_polarity_select_idx, 8'h00);
    chk("pol rst2", edge_polarity_rst, rd);
    apb(1'b0, irq_mask_idx, 8'h00);
    chk("msk rst2", irq_mask_rst, rd);
    chk("irq rst2", 8'h00, {7'h0, irq});
    stop_test();
  end
  irq_src_model far (.pclk(pclk), .presetn(presetn), .level(level),
                     .sources(sources));
  irq_edge_select uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sources(sources), .requests(requests), .irq(irq));
endmodule : testbench
bind irq_edge_select irq_edge_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .sources(sources), .requests(requests));
